/* File: sdp_data_port.v */
// Data-port core of a synchronous flow-through burst SRAM.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_map.vh"
// How it works
// - Data and parity inputs are captured into a data register on each accepted rising clock edge.
// - A read drives out the word at the address sampled on the previous edge, flow-through with no extra stage.
// - With output enable low and no mask, data and parity lines are driven.
// - With output enable high, data and parity lines are released to act as inputs.
// - During a write data phase the lines are released whatever output enable says.
// - In the first cycle after leaving the deselected state the outputs stay released.
// - While deselected the outputs stay released whatever output enable says.
// - Parity bits behave as data and are written only when their own lane select is active.
// - With the order strap low the burst counter steps linearly.
// - With the order strap high the burst counter steps interleaved; there is no pull-up, so a floating strap is not defined.
// - Byte-write selects are qualified by write enable so only selected lanes are written.
// - With clock enable high the device ignores edges and extends the previous cycle without deselecting.
// - With clock enable active, advance high steps the burst counter and low loads a new address.
module sdp_data_port (
  input wire clk,
  input wire reset,
  input wire [`SDP_ADDR_W-1:0] addr,
  input wire write_enable_n,
  input wire [`SDP_LANES-1:0] byte_write_select_n,
  input wire clock_qualifier_n,
  input wire advance_or_load,
  input wire chip_select_1_n,
  input wire chip_select_2,
  input wire chip_select_3_n,
  input wire output_enable_n,
  input wire burst_order,
  input wire [`SDP_DATA_W-1:0] data_in,
  output wire [`SDP_DATA_W-1:0] data_out,
  output wire data_oe,
  input wire [`SDP_LANES-1:0] parity_in,
  output wire [`SDP_LANES-1:0] parity_out,
  output wire parity_oe
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Output enable is asynchronous at the pin, so it passes two flops; the strap is slow and gets the same.
  reg oe_n_s1_ff;
  reg oe_n_s2_ff;
  reg order_s1_ff;
  reg order_s2_ff;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      oe_n_s1_ff <= 1'b1;
      oe_n_s2_ff <= 1'b1;
      order_s1_ff <= 1'b1;
      order_s2_ff <= 1'b1;
    end else begin
      oe_n_s1_ff <= output_enable_n;
      oe_n_s2_ff <= oe_n_s1_ff;
      order_s1_ff <= burst_order;
      order_s2_ff <= order_s1_ff;
    end
  end

  // ****************************************
  // Cycle decode
  // ****************************************
  function sel_decode;
    input cs1_n;
    input cs2;
    input cs3_n;
    begin
      sel_decode = ~cs1_n & cs2 & ~cs3_n;
    end
  endfunction

  wire accept = ~clock_qualifier_n;
  wire load = accept & ~advance_or_load;
  wire step = accept & advance_or_load;
  wire selected = sel_decode(chip_select_1_n, chip_select_2, chip_select_3_n);

  // Select and direction are only re-sampled on loads; a suspended edge holds everything.
  reg sel_ff;
  reg was_sel_ff;
  reg wr_ff;
  reg [`SDP_ADDR_W-1:0] addr_ff;
  reg [`SDP_LANES-1:0] bw_ff;
  reg [`SDP_DATA_W-1:0] din_ff;
  reg [`SDP_LANES-1:0] pin_ff;
  reg nxt_sel;
  reg nxt_wr;
  reg [`SDP_ADDR_W-1:0] nxt_addr;
  reg [`SDP_LANES-1:0] nxt_bw;

  always @* begin
    nxt_sel = sel_ff;
    nxt_wr = wr_ff;
    nxt_addr = addr_ff;
    nxt_bw = bw_ff;
    if (load) begin
      nxt_sel = selected;
      nxt_wr = ~write_enable_n;
      nxt_addr = addr;
      nxt_bw = ~byte_write_select_n & {`SDP_LANES{~write_enable_n}};
    end else if (step) begin
      nxt_bw = ~byte_write_select_n & {`SDP_LANES{wr_ff}};
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sel_ff <= 1'b0;
      was_sel_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= {`SDP_ADDR_W{1'b0}};
      bw_ff <= {`SDP_LANES{1'b0}};
      din_ff <= {`SDP_DATA_W{1'b0}};
      pin_ff <= {`SDP_LANES{1'b0}};
    end else if (accept) begin
      sel_ff <= nxt_sel;
      was_sel_ff <= sel_ff;
      wr_ff <= nxt_wr;
      addr_ff <= nxt_addr;
      bw_ff <= nxt_bw;
      din_ff <= data_in;
      pin_ff <= parity_in;
    end
  end

  // ****************************************
  // Burst counter
  // ****************************************
  wire [`SDP_BURST_W-1:0] burst_lo;
  sdp_burst_ctr u_burst (
    .clk(clk),
    .reset(reset),
    .step_en(step),
    .load_en(load),
    .start_val(addr[`SDP_BURST_W-1:0]),
    .order_sel(order_s2_ff),
    .burst_addr(burst_lo)
  );

  wire [`SDP_ADDR_W-1:0] cur_addr = {addr_ff[`SDP_ADDR_W-1:`SDP_BURST_W], burst_lo};

  // ****************************************
  // Storage array
  // ****************************************
  // Write data lands one edge after the address, so the write uses the previous cycle's address.
  reg [`SDP_BYTE_W-1:0] mem_ff [0:`SDP_DEPTH*`SDP_LANES-1];
  reg mpar_ff [0:`SDP_DEPTH*`SDP_LANES-1];
  reg [`SDP_ADDR_W-1:0] waddr_ff;
  reg [`SDP_LANES-1:0] wlane_ff;
  reg wphase_ff;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      waddr_ff <= {`SDP_ADDR_W{1'b0}};
      wlane_ff <= {`SDP_LANES{1'b0}};
      wphase_ff <= 1'b0;
    end else if (accept) begin
      waddr_ff <= cur_addr;
      wlane_ff <= bw_ff;
      wphase_ff <= sel_ff & wr_ff;
    end
  end

  // Array read ports, full word and parity width, declared ahead of the lane loop that drives them.
  wire [`SDP_DATA_W-1:0] data_out_w;
  wire [`SDP_LANES-1:0] parity_out_w;

  genvar g;
  generate
    for (g = 0; g < `SDP_LANES; g = g + 1) begin : g_lane
      // Each lane, parity included, is written only under its own select.
      always @(posedge clk) begin
        if (accept & wphase_ff & wlane_ff[g]) begin
          mem_ff[waddr_ff*`SDP_LANES+g] <= din_ff[g*`SDP_BYTE_W +: `SDP_BYTE_W];
          mpar_ff[waddr_ff*`SDP_LANES+g] <= pin_ff[g];
        end
      end
      assign data_out_w[g*`SDP_BYTE_W +: `SDP_BYTE_W] = mem_ff[cur_addr*`SDP_LANES+g];
      assign parity_out_w[g] = mpar_ff[cur_addr*`SDP_LANES+g];
    end
  endgenerate

  // ****************************************
  // Output data and direction
  // ****************************************
  // Flow-through: the array flops are read straight at the registered address, so a read word
  // appears in the cycle right after its address edge. An extra output flop here would push read
  // data into the next cycle and collide with the write data of a read followed by a write.
  assign data_out = data_out_w;
  assign parity_out = parity_out_w;

  // The data phase is the cycle after the address edge, so the registered select and direction
  // of that edge decide it; a write phase, a deselect and the first selected cycle all mask it.
  wire rd_phase = sel_ff & ~wr_ff;
  wire emerging = ~was_sel_ff;
  wire drive = rd_phase & ~emerging & ~oe_n_s2_ff;
  assign data_oe = drive;
  assign parity_oe = drive;
endmodule
`default_nettype wire

/* File: sdp_map.vh */
// Constants for the flow-through burst SRAM data port.
`ifndef SDP_MAP_VH
`define SDP_MAP_VH
// ****************************************
// Widths
// ****************************************
`define SDP_ADDR_W 8
`define SDP_BYTE_W 8
`define SDP_LANES 4
`define SDP_DATA_W 32
`define SDP_DEPTH 256
`define SDP_BURST_W 2
// ****************************************
// Burst order strap and burst counter constants
// ****************************************
`define SDP_ORDER_LINEAR 1'b0
`define SDP_BURST_ONE 2'h1
`define SDP_BURST_ZERO 2'h0
`endif

/* File: sdp_burst_ctr.v */
// Two-bit burst address counter with linear or interleaved stepping.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_map.vh"
module sdp_burst_ctr (
  input wire clk,
  input wire reset,
  input wire step_en,
  input wire load_en,
  input wire [`SDP_BURST_W-1:0] start_val,
  input wire order_sel,
  output wire [`SDP_BURST_W-1:0] burst_addr
);
  reg [`SDP_BURST_W-1:0] start_ff;
  reg [`SDP_BURST_W-1:0] count_ff;
  reg [`SDP_BURST_W-1:0] nxt_start;
  reg [`SDP_BURST_W-1:0] nxt_count;

  // ****************************************
  // Counter state
  // ****************************************
  // A load restarts the count from the external low bits; a step bumps the running count.
  always @* begin
    nxt_start = start_ff;
    nxt_count = count_ff;
    if (load_en) begin
      nxt_start = start_val;
      nxt_count = `SDP_BURST_ZERO;
    end else if (step_en) begin
      nxt_count = count_ff + `SDP_BURST_ONE;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      start_ff <= `SDP_BURST_ZERO;
      count_ff <= `SDP_BURST_ZERO;
    end else begin
      start_ff <= nxt_start;
      count_ff <= nxt_count;
    end
  end

  // Linear adds the count modulo four, interleaved XORs it with the start.
  assign burst_addr = (order_sel == `SDP_ORDER_LINEAR) ? (start_ff + count_ff) : (start_ff ^ count_ff);
endmodule
`default_nettype wire

/* File: sdp_data_port_asserts.sv */
// Checker for the output drive and hold rules of the data port.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_map.vh"
module sdp_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic write_enable_n,
  input wire logic clock_qualifier_n,
  input wire logic advance_or_load,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic output_enable_n,
  input wire logic [`SDP_DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic [`SDP_LANES-1:0] parity_out,
  input wire logic parity_oe
);
  // Decoded select and accepted load; windows below are wide enough to allow either drive alignment.
  wire sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  wire ld = !clock_qualifier_n && !advance_or_load;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ****************************************
  // Drive rules
  // ****************************************
  oe_off_a: assert property ((output_enable_n && !clock_qualifier_n) [*3] |=> !data_oe)
    else $error("drive while output enable high");
  par_track_a: assert property (parity_oe == data_oe)
    else $error("parity drive differs from data drive");
  desel_off_a: assert property ((ld && !sel) [*3] |=> !data_oe)
    else $error("drive while deselected");
  wr_off_a: assert property (ld && sel && !write_enable_n |=> !data_oe)
    else $error("drive in write data phase");
  emerge_off_a: assert property (ld && !sel ##1 ld && sel |=> !data_oe)
    else $error("drive in first cycle after deselect");
  rd_drive_a: assert property ((ld && sel && write_enable_n && !output_enable_n) [*3] |=> data_oe)
    else $error("no drive during read run");
  hold_a: assert property (clock_qualifier_n |=> $stable(data_out) && $stable(parity_out))
    else $error("output changed on ignored edge");
  oe_rise_a: assert property ($rose(data_oe) |-> $past(output_enable_n, 2) == 1'b0)
    else $error("drive began without output enable");
  cover property (ld && sel && !write_enable_n);
  cover property ($rose(data_oe));
  cover property (clock_qualifier_n && data_oe);
endmodule
`default_nettype wire

/* File: sdp_ctl_model.sv */
// Far-side controller pin model that resolves the shared data and parity wires.
`timescale 1ns/1ps
`default_nettype none
module sdp_ctl_model (
  input wire logic clk,
  input wire logic [35:0] dev_q,
  input wire logic dev_oe,
  input wire logic [35:0] ctl_q,
  input wire logic ctl_oe,
  output logic [35:0] pin_q
);
  // A released wire shows the inverse of its last level, so a stale value never reads as a match.
  logic [35:0] last_ff = 36'h0;
  always @(posedge clk) begin
    last_ff <= pin_q;
  end
  // The controller drives only in write data phases, all 36 wires at once.
  always @* begin
    pin_q = ctl_oe ? ctl_q : (dev_oe ? dev_q : ~last_ff);
  end
endmodule
`default_nettype wire

/* File: sdp_data_port_tb.sv */
// Self-checking bench for the flow-through SRAM data port.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_map.vh"
module sdp_data_port_tb;
  logic clk, reset, we_n, cq_n, adv, cs1_n, oe_n, mode, ctl_oe;
  logic [7:0] addr;
  logic [3:0] bw_n;
  logic [35:0] ctl_q, pin_q;
  logic [35:0] mem [0:3];
  wire [31:0] dout;
  wire [3:0] pout;
  wire doe, poe;
  int num_errors = 0, cmp_count = 0, ticks = 0;
  sdp_data_port i_dut (.clk(clk), .reset(reset), .addr(addr), .write_enable_n(we_n), .byte_write_select_n(bw_n),
    .clock_qualifier_n(cq_n), .advance_or_load(adv), .chip_select_1_n(cs1_n), .chip_select_2(1'b1),
    .chip_select_3_n(1'b0), .output_enable_n(oe_n), .burst_order(mode), .data_in(pin_q[31:0]),
    .data_out(dout), .data_oe(doe), .parity_in(pin_q[35:32]), .parity_out(pout), .parity_oe(poe));
  sdp_ctl_model i_ctl (.clk(clk), .dev_q({pout, dout}), .dev_oe(doe), .ctl_q(ctl_q), .ctl_oe(ctl_oe), .pin_q(pin_q));
  // Free-running clock and a hang limit far above the fifty-odd cycles the run needs.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 2000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus cycle: inputs change at the falling edge and are taken at the next rising edge.
  task automatic cy(input logic [7:0] a, input logic w, input logic [3:0] b, input logic ad, input logic s,
    input logic d, input logic [35:0] q);
    @(negedge clk);
    addr = a;
    we_n = w;
    bw_n = b;
    adv = ad;
    cs1_n = ~s;
    ctl_oe = d;
    ctl_q = q;
    @(posedge clk);
    #1;
  endtask
  initial begin
    reset = 1'b1;
    {addr, we_n, bw_n, cq_n, adv, cs1_n, oe_n, mode, ctl_oe, ctl_q} = {8'h0, 1'b1, 4'hf, 3'h1, 2'h0, 37'h0};
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    // Back-to-back writes, each word sent in the cycle after its address, ending in a deselect.
    for (int i = 0; i < 5; i++) begin
      if (i < 4) mem[i] = {4'(i), {4{4'ha, 4'(i)}}};
      cy(8'h10 + 8'(i), i == 4, 4'h0, 1'b0, i < 4, i > 0, i > 0 ? mem[i - 1] : 36'h0);
    end
    // Lanes one and three only; parity follows its own lane.
    cy(8'h11, 1'b0, 4'h5, 1'b0, 1'b1, 1'b0, 36'h0);
    cy(8'h00, 1'b1, 4'hf, 1'b0, 1'b0, 1'b1, 36'hf_ffff_ffff);
    mem[1] = mem[1] | 36'ha_ff00_ff00;
    // Reads straight after a deselect; flow-through puts each word out in the cycle after its edge.
    for (int i = 0; i < 4; i++) begin
      cy(8'h10 + 8'(i), 1'b1, 4'hf, 1'b0, 1'b1, 1'b0, 36'h0);
      chk("read word", mem[i], {pout, dout});
    end
    chk("read drive", 36'h1, {35'h0, doe});
    // Ignored edges hold word and drive.
    @(negedge clk);
    cq_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("held word", mem[3], {pout, dout});
    chk("held drive", 36'h1, {35'h0, doe});
    cq_n = 1'b0;
    // Burst from an odd start, linear then interleaved; strap settles before each run.
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      mode = 1'(m);
      repeat (3) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
        cy(8'h11, 1'b1, 4'hf, i > 0, 1'b1, 1'b0, 36'h0);
        chk("burst word", mem[m ? 1 ^ i : (1 + i) % 4], {pout, dout});
      end
    end
    @(negedge clk);
    oe_n = 1'b1;
    repeat (4) cy(8'h10, 1'b1, 4'hf, 1'b0, 1'b1, 1'b0, 36'h0);
    chk("disabled drive", 36'h0, {35'h0, doe});
    @(negedge clk);
    oe_n = 1'b0;
    repeat (4) cy(8'h10, 1'b1, 4'hf, 1'b0, 1'b1, 1'b0, 36'h0);
    // Write right after reads, then a deselected stretch and a read back.
    cy(8'h12, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 36'h0);
    chk("write drive", 36'h0, {35'h0, doe});
    cy(8'h00, 1'b1, 4'hf, 1'b0, 1'b0, 1'b1, 36'h5_a5a5_a5a5);
    repeat (3) cy(8'h00, 1'b1, 4'hf, 1'b0, 1'b0, 1'b0, 36'h0);
    chk("deselect drive", 36'h0, {35'h0, doe});
    cy(8'h12, 1'b1, 4'hf, 1'b0, 1'b1, 1'b0, 36'h0);
    chk("emerge drive", 36'h0, {35'h0, doe});
    cy(8'h12, 1'b1, 4'hf, 1'b0, 1'b1, 1'b0, 36'h0);
    chk("rewritten word", 36'h5_a5a5_a5a5, {pout, dout});
    final_report;
  end
endmodule
bind sdp_data_port sdp_chk i_chk (.clk(clk), .reset(reset), .write_enable_n(write_enable_n),
  .clock_qualifier_n(clock_qualifier_n), .advance_or_load(advance_or_load), .chip_select_1_n(chip_select_1_n),
  .chip_select_2(chip_select_2), .chip_select_3_n(chip_select_3_n), .output_enable_n(output_enable_n),
  .data_out(data_out), .data_oe(data_oe), .parity_out(parity_out), .parity_oe(parity_oe));
`default_nettype wire
